// [rtl/sfcfe_device.sv]
// Flash command front end: decodes the serial link and streams read data
`timescale 1ns/1ps
module sfcfe_device #(
	parameter int FIFO_DEPTH = 4
)(
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic ce_i,
	sfcfe_if.dev link,
	input wire logic [7:0] rd_data_i,
	input wire logic rd_valid_i,
	output logic rd_ready_o,
	output logic cmd_valid_o,
	output logic [7:0] cmd_opcode_o,
	output logic [20:0] cmd_addr_o,
	output logic cmd_cont_o,
	output logic end_o
);
	typedef enum logic [2:0] {ST_IDLE, ST_OPC, ST_ADDR, ST_DUMMY, ST_DATA, ST_HOLD, ST_IGNORE} sfcfe_dev_e;

	// =====================================================
	// Link synchronisers
	// =====================================================
	logic [5:0] sync1_reg, sync2_reg;
	logic [1:0] prev_reg;
	logic desel, rise, fall, cs_rel;
	logic [3:0] io_s;

	// Chip select, clock and pins through two flops
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			sync1_reg <= 6'h20;
			sync2_reg <= 6'h20;
			prev_reg <= 2'h2;
		end
		else if (ce_i)
		begin
			sync1_reg <= {link.cs_n, link.sclk, link.io};
			sync2_reg <= sync1_reg;
			prev_reg <= sync2_reg[5:4];
		end
	end

	// Only edges seen while already selected count, so a clock level set with select is no edge
	assign desel = sync2_reg[5];
	assign rise = ~desel & ~prev_reg[1] & sync2_reg[4] & ~prev_reg[0];
	assign fall = ~desel & ~prev_reg[1] & ~sync2_reg[4] & prev_reg[0];
	assign cs_rel = desel & ~prev_reg[1];
	assign io_s = sync2_reg[3:0];

	// =====================================================
	// Read data buffer
	// =====================================================
	logic fifo_valid, pop;
	logic [7:0] fifo_data;

	sfcfe_fifo #(
		.W(8),
		.D(FIFO_DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.ce_i(ce_i),
		.flush_i(desel),
		.in_valid_i(rd_valid_i),
		.in_ready_o(rd_ready_o),
		.in_data_i(rd_data_i),
		.out_valid_o(fifo_valid),
		.out_ready_i(pop),
		.out_data_o(fifo_data)
	);

	// =====================================================
	// Command decoder
	// =====================================================
	sfcfe_dev_e state_reg, state_next;
	logic [5:0] cnt_reg, cnt_next;
	logic [7:0] op_reg, op_next;
	sfcfe_pkg::sfcfe_cmd_s cmd_reg, cmd_next, dec;
	logic [31:0] sr_reg, sr_next;
	logic cont_reg, cont_next, run_cont_reg, run_cont_next;
	logic [7:0] out_reg, out_next, byte_v;
	logic [3:0] rem_reg, rem_next;
	logic [3:0] io_reg, io_next, oe_reg, oe_next;
	logic cmd_valid_reg, cmd_valid_next, end_reg, end_next;
	logic [20:0] addr_reg, addr_next;

	// Next state of the decoder and output shifter
	always_comb
	begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		op_next = op_reg;
		cmd_next = cmd_reg;
		sr_next = sr_reg;
		cont_next = cont_reg;
		run_cont_next = run_cont_reg;
		out_next = out_reg;
		rem_next = rem_reg;
		io_next = io_reg;
		oe_next = oe_reg;
		cmd_valid_next = 1'b0;
		end_next = 1'b0;
		addr_next = addr_reg;
		pop = 1'b0;
		byte_v = out_reg;
		dec = sfcfe_pkg::sfcfe_decode({sr_reg[6:0], io_s[0]});
		if (desel)
		begin
			state_next = ST_IDLE;
			oe_next = sfcfe_pkg::OE_NONE;
			rem_next = 4'h0;
			if (cs_rel)
			begin
				end_next = 1'b1;
				cmd_valid_next = state_reg == ST_HOLD;
			end
		end
		else
		begin
			unique case (state_reg)
				ST_IDLE:
				begin
					// Continuous read skips the opcode
					cnt_next = 6'h00;
					run_cont_next = cont_reg;
					state_next = cont_reg ? ST_ADDR : ST_OPC;
				end
				ST_OPC:
				begin
					if (rise)
					begin
						sr_next = sfcfe_pkg::sfcfe_shl(sr_reg, io_s, sfcfe_pkg::LN1);
						cnt_next = 6'(cnt_reg + 1'b1);
						if (cnt_reg == 6'(sfcfe_pkg::OPC_CLKS - 1'b1))
						begin
							op_next = sr_next[7:0];
							cmd_next = dec;
							cnt_next = 6'h00;
							cont_next = 1'b0;
							if (!dec.ok)
								state_next = ST_IGNORE;
							else if (dec.has_addr)
								state_next = ST_ADDR;
							else
								state_next = ST_HOLD;
						end
					end
				end
				ST_ADDR:
				begin
					if (rise)
					begin
						sr_next = sfcfe_pkg::sfcfe_shl(sr_reg, io_s, cmd_reg.addr_ln);
						cnt_next = 6'(cnt_reg + 1'b1);
						if (cnt_reg == 6'(cmd_reg.adr_clks - 1'b1))
						begin
							cnt_next = 6'h00;
							cmd_valid_next = 1'b1;
							if (cmd_reg.has_mode)
								addr_next = sr_next[sfcfe_pkg::ADDR_KEEP+7:8];
							else
								addr_next = sr_next[sfcfe_pkg::ADDR_KEEP-1:0];
							cont_next = cmd_reg.has_mode &&
								((sr_next[7:0] & sfcfe_pkg::CONT_MASK) == sfcfe_pkg::CONT_VAL);
							state_next = (cmd_reg.dummy == sfcfe_pkg::DUMMY_NONE) ? ST_DATA : ST_DUMMY;
						end
					end
				end
				ST_DUMMY:
				begin
					if (rise)
					begin
						cnt_next = 6'(cnt_reg + 1'b1);
						if (cnt_reg == 6'(cmd_reg.dummy - 1'b1))
							state_next = ST_DATA;
					end
				end
				ST_DATA:
				begin
					// Pins turn to outputs for the data phase
					oe_next = sfcfe_pkg::sfcfe_oe(cmd_reg.data_ln, sfcfe_pkg::OE_SO);
					if (fall)
					begin
						if (rem_reg == 4'h0)
						begin
							pop = fifo_valid;
							byte_v = fifo_valid ? fifo_data : sfcfe_pkg::FILL_BYTE;
							rem_next = 4'(4'h8 - {1'b0, cmd_reg.data_ln});
						end
						else
							rem_next = 4'(rem_reg - {1'b0, cmd_reg.data_ln});
						io_next = sfcfe_pkg::sfcfe_pins(byte_v[7:4], cmd_reg.data_ln, 1'b1);
						out_next = 8'(byte_v << cmd_reg.data_ln);
					end
				end
				ST_HOLD, ST_IGNORE:
				begin
					// Wait for release; input is disregarded
					state_next = state_reg;
				end
				default: state_next = ST_IGNORE;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			state_reg <= ST_IDLE;
			cnt_reg <= 6'h00;
			op_reg <= 8'h00;
			cmd_reg <= '0;
			sr_reg <= 32'h0;
			cont_reg <= 1'b0;
			run_cont_reg <= 1'b0;
			out_reg <= 8'h00;
			rem_reg <= 4'h0;
			io_reg <= 4'h0;
			oe_reg <= 4'h0;
			cmd_valid_reg <= 1'b0;
			end_reg <= 1'b0;
			addr_reg <= 21'h0;
		end
		else if (ce_i)
		begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			op_reg <= op_next;
			cmd_reg <= cmd_next;
			sr_reg <= sr_next;
			cont_reg <= cont_next;
			run_cont_reg <= run_cont_next;
			out_reg <= out_next;
			rem_reg <= rem_next;
			io_reg <= io_next;
			oe_reg <= oe_next;
			cmd_valid_reg <= cmd_valid_next;
			end_reg <= end_next;
			addr_reg <= addr_next;
		end
	end

	// Registered outputs
	assign link.dev_io_o = io_reg;
	assign link.dev_io_oe = oe_reg;
	assign cmd_valid_o = cmd_valid_reg;
	assign cmd_opcode_o = op_reg;
	assign cmd_addr_o = addr_reg;
	assign cmd_cont_o = run_cont_reg;
	assign end_o = end_reg;
endmodule

// [rtl/sfcfe_fifo.sv]
// Small read data FIFO with valid and ready on both sides
`timescale 1ns/1ps
module sfcfe_fifo #(
	parameter int W = 8,
	parameter int D = 4
)(
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic ce_i,
	input wire logic flush_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [W-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [W-1:0] out_data_o
);
	localparam int AW = (D > 1) ? $clog2(D) : 1;

	logic [W-1:0] mem [D];
	logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
	logic [AW:0] cnt_reg, cnt_next;
	logic push, pop;

	assign in_ready_o = cnt_reg != (AW+1)'(D);
	assign out_valid_o = cnt_reg != '0;
	assign out_data_o = mem[rd_reg];
	assign push = in_valid_i & in_ready_o & ~flush_i;
	assign pop = out_valid_o & out_ready_i & ~flush_i;

	// Pointer and fill level update
	always_comb
	begin
		wr_next = wr_reg;
		rd_next = rd_reg;
		cnt_next = cnt_reg;
		if (flush_i)
		begin
			wr_next = '0;
			rd_next = '0;
			cnt_next = '0;
		end
		else
		begin
			if (push)
				wr_next = (wr_reg == AW'(D - 1)) ? '0 : AW'(wr_reg + 1'b1);
			if (pop)
				rd_next = (rd_reg == AW'(D - 1)) ? '0 : AW'(rd_reg + 1'b1);
			cnt_next = (AW+1)'(cnt_reg + push - pop);
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
		end
		else if (ce_i)
		begin
			wr_reg <= wr_next;
			rd_reg <= rd_next;
			cnt_reg <= cnt_next;
		end
	end

	// Storage, written only on accepted words
	always_ff @(posedge clk_i)
	begin
		if (ce_i && push)
			mem[wr_reg] <= in_data_i;
	end
endmodule

// [rtl/sfcfe_host.sv]
// Host controller end: makes the serial clock and runs one command
`timescale 1ns/1ps
module sfcfe_host #(
	parameter int HALF = sfcfe_pkg::SCLK_HALF,
	parameter int LEN_W = 8
)(
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic ce_i,
	sfcfe_if.host link,
	input wire logic req_valid_i,
	output logic req_ready_o,
	input wire logic [7:0] req_opcode_i,
	input wire logic [23:0] req_addr_i,
	input wire logic [7:0] req_mode_i,
	input wire logic req_cont_i,
	input wire logic req_mode3_i,
	input wire logic [LEN_W-1:0] req_len_i,
	output logic [7:0] rx_data_o,
	output logic rx_valid_o,
	output logic done_o
);
	typedef enum logic [1:0] {HS_IDLE, HS_RUN, HS_TAIL} sfcfe_host_e;

	sfcfe_host_e state_reg, state_next;
	logic [15:0] div_reg, div_next;
	logic sclk_reg, sclk_next, cs_n_reg, cs_n_next, m3_reg, m3_next;
	logic [3:0] io_reg, io_next, oe_reg, oe_next, io1_reg, io2_reg;
	logic [39:0] tx_reg, tx_next;
	logic [11:0] k_reg, k_next, p1_reg, p1_next, p2_reg, p2_next, p3_reg, p3_next, p4_reg, p4_next;
	sfcfe_pkg::sfcfe_cmd_s cmd_reg, cmd_next, dec;
	logic [31:0] rx_sr_reg, rx_sr_next;
	logic [3:0] rx_cnt_reg, rx_cnt_next;
	logic [7:0] rx_reg, rx_next;
	logic rxv_reg, rxv_next, done_reg, done_next, rdy_reg, rdy_next, tick;
	logic [2:0] sh;

	// Pins driven for clock index k: opcode on io0, then address lanes
	function automatic logic [7:0] drv(input logic [11:0] k, input logic [39:0] tx, input logic [11:0] p1,
		input logic [11:0] p2, input logic [2:0] aln);
		logic [7:0] r;
		r = {sfcfe_pkg::OE_NONE, 4'h0};
		if (k < p1)
			r = {sfcfe_pkg::OE_SI, sfcfe_pkg::sfcfe_pins(tx[39:36], sfcfe_pkg::LN1, 1'b0)};
		else if (k < p2)
			r = {sfcfe_pkg::sfcfe_oe(aln, sfcfe_pkg::OE_SI), sfcfe_pkg::sfcfe_pins(tx[39:36], aln, 1'b0)};
		return r;
	endfunction

	// Device pins through two flops
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			io1_reg <= 4'h0;
			io2_reg <= 4'h0;
		end
		else if (ce_i)
		begin
			io1_reg <= link.io;
			io2_reg <= io1_reg;
		end
	end

	assign tick = div_reg == 16'(HALF - 1);

	// Sequencer: clock divider, shifters and phase bounds
	always_comb
	begin
		state_next = state_reg;
		div_next = 16'(div_reg + 1'b1);
		sclk_next = sclk_reg;
		cs_n_next = cs_n_reg;
		m3_next = m3_reg;
		io_next = io_reg;
		oe_next = oe_reg;
		tx_next = tx_reg;
		k_next = k_reg;
		p1_next = p1_reg;
		p2_next = p2_reg;
		p3_next = p3_reg;
		p4_next = p4_reg;
		cmd_next = cmd_reg;
		rx_sr_next = rx_sr_reg;
		rx_cnt_next = rx_cnt_reg;
		rx_next = rx_reg;
		rxv_next = 1'b0;
		done_next = 1'b0;
		rdy_next = rdy_reg;
		dec = sfcfe_pkg::sfcfe_decode(req_opcode_i);
		sh = (dec.data_ln == sfcfe_pkg::LN4) ? 3'h2 : ((dec.data_ln == sfcfe_pkg::LN2) ? 3'h1 : 3'h0);
		unique case (state_reg)
			HS_IDLE:
			begin
				div_next = 16'h0;
				sclk_next = req_mode3_i;
				if (req_valid_i)
				begin
					// Select, load the frame and drive the first bits
					cs_n_next = 1'b0;
					m3_next = req_mode3_i;
					rdy_next = 1'b0;
					cmd_next = dec;
					k_next = 12'h0;
					rx_cnt_next = 4'h0;
					p1_next = req_cont_i ? 12'h0 : 12'(sfcfe_pkg::OPC_CLKS);
					p2_next = 12'(p1_next + (dec.has_addr ? dec.adr_clks : 6'h00));
					p3_next = 12'(p2_next + dec.dummy);
					p4_next = 12'(p3_next + (dec.has_addr ? 12'({req_len_i, 3'b000} >> sh) : 12'h0));
					if (req_cont_i)
						tx_next = {req_addr_i, req_mode_i, 8'h00};
					else if (dec.has_mode)
						tx_next = {req_opcode_i, req_addr_i, req_mode_i};
					else
						tx_next = {req_opcode_i, req_addr_i, 8'h00};
					{oe_next, io_next} = drv(12'h0, tx_next, p1_next, p2_next, dec.addr_ln);
					state_next = HS_RUN;
				end
			end
			HS_RUN:
			begin
				if (tick)
				begin
					div_next = 16'h0;
					sclk_next = ~sclk_reg;
					if (!sclk_reg)
					begin
						// Rising edge: device samples, host samples data
						k_next = 12'(k_reg + 1'b1);
						if (k_reg >= p3_reg && k_reg < p4_reg)
						begin
							// Single lane data returns on serial out, not serial in
							rx_sr_next = sfcfe_pkg::sfcfe_shl(rx_sr_reg,
								(cmd_reg.data_ln == sfcfe_pkg::LN1) ? {3'b000, io2_reg[1]} : io2_reg,
								cmd_reg.data_ln);
							rx_cnt_next = 4'(rx_cnt_reg + cmd_reg.data_ln);
							if (rx_cnt_next == 4'h8)
							begin
								rx_cnt_next = 4'h0;
								rx_next = rx_sr_next[7:0];
								rxv_next = 1'b1;
							end
						end
						if (k_next == p4_reg)
							state_next = HS_TAIL;
					end
					else if (k_reg != 12'h0)
					begin
						// Falling edge: next bits, pins released after address
						tx_next = tx_reg << ((k_reg <= p1_reg) ? sfcfe_pkg::LN1 : cmd_reg.addr_ln);
						{oe_next, io_next} = drv(k_reg, tx_next, p1_reg, p2_reg, cmd_reg.addr_ln);
					end
				end
			end
			HS_TAIL:
			begin
				if (tick)
				begin
					div_next = 16'h0;
					oe_next = sfcfe_pkg::OE_NONE;
					if (sclk_reg != m3_reg)
						sclk_next = m3_reg;
					else
					begin
						cs_n_next = 1'b1;
						done_next = 1'b1;
						rdy_next = 1'b1;
						state_next = HS_IDLE;
					end
				end
			end
			default: state_next = HS_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			state_reg <= HS_IDLE;
			div_reg <= 16'h0;
			sclk_reg <= 1'b0;
			cs_n_reg <= 1'b1;
			m3_reg <= 1'b0;
			io_reg <= 4'h0;
			oe_reg <= 4'h0;
			tx_reg <= 40'h0;
			k_reg <= 12'h0;
			p1_reg <= 12'h0;
			p2_reg <= 12'h0;
			p3_reg <= 12'h0;
			p4_reg <= 12'h0;
			cmd_reg <= '0;
			rx_sr_reg <= 32'h0;
			rx_cnt_reg <= 4'h0;
			rx_reg <= 8'h00;
			rxv_reg <= 1'b0;
			done_reg <= 1'b0;
			rdy_reg <= 1'b1;
		end
		else if (ce_i)
		begin
			state_reg <= state_next;
			div_reg <= div_next;
			sclk_reg <= sclk_next;
			cs_n_reg <= cs_n_next;
			m3_reg <= m3_next;
			io_reg <= io_next;
			oe_reg <= oe_next;
			tx_reg <= tx_next;
			k_reg <= k_next;
			p1_reg <= p1_next;
			p2_reg <= p2_next;
			p3_reg <= p3_next;
			p4_reg <= p4_next;
			cmd_reg <= cmd_next;
			rx_sr_reg <= rx_sr_next;
			rx_cnt_reg <= rx_cnt_next;
			rx_reg <= rx_next;
			rxv_reg <= rxv_next;
			done_reg <= done_next;
			rdy_reg <= rdy_next;
		end
	end

	// Registered outputs
	assign link.cs_n = cs_n_reg;
	assign link.sclk = sclk_reg;
	assign link.host_io_o = io_reg;
	assign link.host_io_oe = oe_reg;
	assign req_ready_o = rdy_reg;
	assign rx_data_o = rx_reg;
	assign rx_valid_o = rxv_reg;
	assign done_o = done_reg;
endmodule

// [rtl/sfcfe_if.sv]
// Serial link between flash front end and host controller
`timescale 1ns/1ps
interface sfcfe_if;
	logic cs_n;
	logic sclk;
	logic [3:0] io;
	logic [3:0] dev_io_o;
	logic [3:0] dev_io_oe;
	logic [3:0] host_io_o;
	logic [3:0] host_io_oe;

	// Wire level from the enables, pulled high when undriven
	assign io = (dev_io_oe & dev_io_o) | (host_io_oe & host_io_o) | ~(dev_io_oe | host_io_oe);

	modport dev (input cs_n, input sclk, input io, output dev_io_o, output dev_io_oe);
	modport host (output cs_n, output sclk, output host_io_o, output host_io_oe, input io);
endinterface

// [rtl/sfcfe_pkg.sv]
// Shared constants and command decode for the flash command front end
package sfcfe_pkg;
	// Supported opcodes
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_FAST = 8'h0b;
	localparam logic [7:0] OP_DUAL_OUT = 8'h3b;
	localparam logic [7:0] OP_QUAD_OUT = 8'h6b;
	localparam logic [7:0] OP_DUAL_IO = 8'hbb;
	localparam logic [7:0] OP_QUAD_IO = 8'heb;
	localparam logic [7:0] OP_WORD_QIO = 8'he7;
	localparam logic [7:0] OP_VSR_WEN = 8'h50;
	localparam logic [7:0] OP_WEN = 8'h06;
	localparam logic [7:0] OP_WDIS = 8'h04;
	// Lane counts
	localparam logic [2:0] LN1 = 3'h1;
	localparam logic [2:0] LN2 = 3'h2;
	localparam logic [2:0] LN4 = 3'h4;
	// Clock counts per phase
	localparam logic [5:0] OPC_CLKS = 6'h08;
	localparam logic [5:0] ADR_CLK1 = 6'h18;
	localparam logic [5:0] ADR_CLK2 = 6'h0c;
	localparam logic [5:0] ADR_CLK4 = 6'h06;
	localparam logic [5:0] MODE_CLK2 = 6'h04;
	localparam logic [5:0] MODE_CLK4 = 6'h02;
	localparam logic [5:0] DUMMY_STD = 6'h08;
	localparam logic [5:0] DUMMY_QIO = 6'h04;
	localparam logic [5:0] DUMMY_WORD = 6'h02;
	localparam logic [5:0] DUMMY_NONE = 6'h00;
	// Address bits kept by the device
	localparam int ADDR_KEEP = 21;
	// Mode byte pattern that keeps continuous read
	localparam logic [7:0] CONT_MASK = 8'h30;
	localparam logic [7:0] CONT_VAL = 8'h20;
	localparam logic [7:0] FILL_BYTE = 8'hff;
	// Pin enables: io0 is serial in, io1 serial out
	localparam logic [3:0] OE_SI = 4'h1;
	localparam logic [3:0] OE_SO = 4'h2;
	localparam logic [3:0] OE_DUAL = 4'h3;
	localparam logic [3:0] OE_QUAD = 4'hf;
	localparam logic [3:0] OE_NONE = 4'h0;
	// Host half period of the serial clock, in system clocks
	localparam int SCLK_HALF = 16;

	typedef struct packed {
		logic ok;
		logic has_addr;
		logic has_mode;
		logic [2:0] addr_ln;
		logic [2:0] data_ln;
		logic [5:0] adr_clks;
		logic [5:0] dummy;
	} sfcfe_cmd_s;

	// Format of each opcode; address clocks include mode clocks
	function automatic sfcfe_cmd_s sfcfe_decode(input logic [7:0] op);
		sfcfe_cmd_s c;
		c = '0;
		case (op)
			OP_READ: c = '{1'b1, 1'b1, 1'b0, LN1, LN1, ADR_CLK1, DUMMY_NONE};
			OP_FAST: c = '{1'b1, 1'b1, 1'b0, LN1, LN1, ADR_CLK1, DUMMY_STD};
			OP_DUAL_OUT: c = '{1'b1, 1'b1, 1'b0, LN1, LN2, ADR_CLK1, DUMMY_STD};
			OP_QUAD_OUT: c = '{1'b1, 1'b1, 1'b0, LN1, LN4, ADR_CLK1, DUMMY_STD};
			OP_DUAL_IO: c = '{1'b1, 1'b1, 1'b1, LN2, LN2, 6'(ADR_CLK2 + MODE_CLK2), DUMMY_NONE};
			OP_QUAD_IO: c = '{1'b1, 1'b1, 1'b1, LN4, LN4, 6'(ADR_CLK4 + MODE_CLK4), DUMMY_QIO};
			OP_WORD_QIO: c = '{1'b1, 1'b1, 1'b1, LN4, LN4, 6'(ADR_CLK4 + MODE_CLK4), DUMMY_WORD};
			OP_VSR_WEN, OP_WEN, OP_WDIS: c.ok = 1'b1;
			default: c = '0;
		endcase
		return c;
	endfunction

	// Enable mask for a lane count; one lane uses the given pin
	function automatic logic [3:0] sfcfe_oe(input logic [2:0] ln, input logic [3:0] one);
		logic [3:0] m;
		m = OE_NONE;
		if (ln == LN1)
			m = one;
		else if (ln == LN2)
			m = OE_DUAL;
		else if (ln == LN4)
			m = OE_QUAD;
		return m;
	endfunction

	// Top bits of a word onto the pins, highest lane first
	function automatic logic [3:0] sfcfe_pins(input logic [3:0] b, input logic [2:0] ln, input logic so);
		logic [3:0] p;
		p = b;
		if (ln == LN1)
			p = so ? {2'b00, b[3], 1'b0} : {3'b000, b[3]};
		else if (ln == LN2)
			p = {2'b00, b[3:2]};
		return p;
	endfunction

	// Shift pin bits in at the bottom, earlier bits move up
	function automatic logic [31:0] sfcfe_shl(input logic [31:0] sr, input logic [3:0] io, input logic [2:0] ln);
		logic [31:0] r;
		r = {sr[27:0], io};
		if (ln == LN1)
			r = {sr[30:0], io[0]};
		else if (ln == LN2)
			r = {sr[29:0], io[1:0]};
		return r;
	endfunction
endpackage

// [sim/sfcfe_properties.sv]
// Link protocol checker for the flash command front end
`timescale 1ns/1ps
module sfcfe_properties (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic [3:0] dev_io_o,
	input wire logic [3:0] dev_io_oe,
	input wire logic [3:0] host_io_o
);
	// ==========
	// Link timing and pin direction
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!arst_n_i);
	property p_cs_gap;
		$rose(cs_n) |=> cs_n [*3];
	endproperty
	a_cs_gap: assert property (p_cs_gap) else $error("short deselect gap");
	property p_half;
		$changed(sclk) |=> $stable(sclk) [*5];
	endproperty
	a_half: assert property (p_half) else $error("serial clock phase too short");
	property p_host_rise;
		!cs_n && $past(cs_n) == 1'b0 && $rose(sclk) |-> $stable(host_io_o);
	endproperty
	a_host_rise: assert property (p_host_rise) else $error("host data moved at rise");
	property p_dev_fall;
		!cs_n && (dev_io_oe != 4'h0) && ($past(dev_io_oe) != 4'h0) && $changed(dev_io_o) |-> !sclk;
	endproperty
	a_dev_fall: assert property (p_dev_fall) else $error("device data moved with clock high");
	property p_oe_legal;
		dev_io_oe inside {4'h0, 4'h2, 4'h3, 4'hf};
	endproperty
	a_oe_legal: assert property (p_oe_legal) else $error("odd lane enable");
	property p_quad_oe;
		$rose(dev_io_oe[3]) |-> sclk && !cs_n;
	endproperty
	a_quad_oe: assert property (p_quad_oe) else $error("quad turn not after a rise");
	property p_oe_late;
		$rose(|dev_io_oe) |-> $past(cs_n, 8) == 1'b0;
	endproperty
	a_oe_late: assert property (p_oe_late) else $error("device drove too early");
	property p_oe_drop;
		$rose(cs_n) |-> ##[1:6] dev_io_oe == 4'h0;
	endproperty
	a_oe_drop: assert property (p_oe_drop) else $error("pins held after release");
	// ==========
	// Coverage
	c_quad: cover property ($rose(dev_io_oe == 4'hf));
	c_dual: cover property ($rose(dev_io_oe == 4'h3));
	c_frame: cover property ($rose(cs_n));
endmodule

// [sim/sfcfe_tb_top.sv]
// Bench joining host and device ends over the link
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; $display("[ERR] %0t %0h %0h", $time, a, b); end end
module sfcfe_tb_top;
	logic clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic req_valid_i = 1'b0;
	logic req_cont_i = 1'b0;
	logic req_mode3_i = 1'b0;
	logic rd_valid_i = 1'b0;
	logic [7:0] req_opcode_i = 8'h00;
	logic [7:0] req_mode_i = 8'h00;
	logic [7:0] req_len_i = 8'h00;
	logic [7:0] rd_data_i = 8'h00;
	logic [23:0] req_addr_i = 24'h000000;
	logic rx_valid_o, done_o, rd_ready_o, cmd_valid_o, cmd_cont_o, end_o, req_ready_o;
	logic [7:0] rx_data_o, cmd_opcode_o;
	logic [20:0] cmd_addr_o;
	int err_total = 0;
	int checked = 0;
	int n_cmd = 0;
	int n_end = 0;
	sfcfe_if i_sfcfe_if ();
	sfcfe_device i_sfcfe_device (.clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(1'b1), .link(i_sfcfe_if.dev),
		.rd_data_i(rd_data_i), .rd_valid_i(rd_valid_i), .rd_ready_o(rd_ready_o), .cmd_valid_o(cmd_valid_o),
		.cmd_opcode_o(cmd_opcode_o), .cmd_addr_o(cmd_addr_o), .cmd_cont_o(cmd_cont_o), .end_o(end_o));
	sfcfe_host #(.HALF(6)) i_sfcfe_host (.clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(1'b1), .link(i_sfcfe_if.host),
		.req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_opcode_i(req_opcode_i), .req_addr_i(req_addr_i),
		.req_mode_i(req_mode_i), .req_cont_i(req_cont_i), .req_mode3_i(req_mode3_i), .req_len_i(req_len_i),
		.rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o), .done_o(done_o));
	sfcfe_properties i_sfcfe_properties (.clk_i(clk_i), .arst_n_i(arst_n_i), .cs_n(i_sfcfe_if.cs_n),
		.sclk(i_sfcfe_if.sclk), .dev_io_o(i_sfcfe_if.dev_io_o), .dev_io_oe(i_sfcfe_if.dev_io_oe),
		.host_io_o(i_sfcfe_if.host_io_o));
	// ==========
	// Clock and memory side
	always #2 clk_i = ~clk_i;
	// Stream bytes counting up from the address low byte
	always @(posedge clk_i)
	begin
		if (end_o)
			rd_valid_i <= 1'b0;
		else if (cmd_valid_o)
			rd_valid_i <= 1'b1;
		if (cmd_valid_o)
			rd_data_i <= cmd_addr_o[7:0];
		else if (rd_valid_i && rd_ready_o)
			rd_data_i <= rd_data_i + 8'h01;
		n_cmd <= n_cmd + int'(cmd_valid_o);
		n_end <= n_end + int'(end_o);
	end
	// ==========
	// Scenarios
	task automatic give_verdict();
		$display("checked %0d err_total %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// One frame: data, lanes used, opcode bits, frame and command counts
	task automatic xfer(input logic [7:0] op, input logic [23:0] a, input logic [7:0] m, input logic c,
		input logic m3, input logic [3:0] oe_exp, input int n, input int nc);
		int k;
		int t;
		int c0;
		int e0;
		int nr;
		logic [7:0] sh;
		logic [3:0] oe_acc;
		logic ps;
		k = 0;
		nr = 0;
		sh = 8'h00;
		oe_acc = 4'h0;
		ps = m3;
		c0 = n_cmd;
		e0 = n_end;
		@(posedge clk_i);
		req_opcode_i <= op;
		req_addr_i <= a;
		req_mode_i <= m;
		req_cont_i <= c;
		req_mode3_i <= m3;
		req_len_i <= 8'(n);
		req_valid_i <= 1'b1;
		@(posedge clk_i);
		req_valid_i <= 1'b0;
		for (t = 0; t < 20000 && done_o !== 1'b1; t++)
		begin
			@(posedge clk_i);
			#1;
			oe_acc |= i_sfcfe_if.dev_io_oe;
			if (t == 0)
				`CHK(req_ready_o, 1'b0)
			if (i_sfcfe_if.sclk && !ps && !i_sfcfe_if.cs_n && nr < 8)
			begin
				sh = {sh[6:0], i_sfcfe_if.io[0]};
				nr++;
			end
			ps = i_sfcfe_if.sclk;
			if (rx_valid_o === 1'b1)
			begin
				`CHK(rx_data_o, 8'(a[7:0] + 8'(k)))
				k++;
			end
		end
		if (t >= 20000)
		begin
			err_total++;
			give_verdict();
		end
		repeat (12) @(posedge clk_i);
		`CHK(req_ready_o, 1'b1)
		`CHK(k, n)
		`CHK(oe_acc, oe_exp)
		`CHK(n_end - e0, 1)
		`CHK(n_cmd - c0, nc)
		if (!c)
			`CHK(sh, op)
	endtask
	// Every read format, alternating serial clock modes
	task automatic t_reads();
		logic [7:0] ops [7] = '{8'h03, 8'h0b, 8'h3b, 8'h6b, 8'hbb, 8'heb, 8'he7};
		logic [3:0] oes [7] = '{4'h2, 4'h2, 4'h3, 4'hf, 4'h3, 4'hf, 4'hf};
		logic [23:0] a;
		for (int i = 0; i < 7; i++)
		begin
			a = 24'hf45a10 + 24'(i * 37);
			xfer(ops[i], a, 8'h00, 1'b0, i[0], oes[i], 3, 1);
			`CHK(cmd_addr_o, a[20:0])
			`CHK(cmd_opcode_o, ops[i])
		end
	endtask
	// Keep pattern in the mode byte, then a frame without opcode
	task automatic t_cont();
		xfer(8'heb, 24'h1234f0, 8'h20, 1'b0, 1'b0, 4'hf, 2, 1);
		`CHK(cmd_cont_o, 1'b0)
		xfer(8'heb, 24'h0abc05, 8'h00, 1'b1, 1'b0, 4'hf, 2, 1);
		`CHK(cmd_cont_o, 1'b1)
		`CHK(cmd_addr_o, 21'h0abc05)
		xfer(8'hbb, 24'h0f0f33, 8'h20, 1'b0, 1'b1, 4'h3, 2, 1);
		`CHK(cmd_cont_o, 1'b0)
		xfer(8'hbb, 24'h1a2b3c, 8'h00, 1'b1, 1'b1, 4'h3, 2, 1);
		`CHK(cmd_cont_o, 1'b1)
		`CHK(cmd_addr_o, 21'h1a2b3c)
	endtask
	// Unknown opcode starts nothing; opcode-only command completes
	task automatic t_short();
		xfer(8'hc3, 24'h000000, 8'h00, 1'b0, 1'b0, 4'h0, 0, 0);
		xfer(8'h50, 24'h000000, 8'h00, 1'b0, 1'b1, 4'h0, 0, 1);
		`CHK(cmd_opcode_o, 8'h50)
		xfer(8'h06, 24'h000000, 8'h00, 1'b0, 1'b0, 4'h0, 0, 1);
		`CHK(cmd_opcode_o, 8'h06)
		xfer(8'h04, 24'h000000, 8'h00, 1'b0, 1'b1, 4'h0, 0, 1);
		`CHK(cmd_opcode_o, 8'h04)
	endtask
	// ==========
	// Main sequence
	initial
	begin
		repeat (16) @(posedge clk_i);
		arst_n_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		t_reads();
		t_cont();
		t_short();
		give_verdict();
	end
endmodule
